// ### bench/dimc_properties.sv
`timescale 1ns/1ps
module dimc_properties
    import dimc_pkg::*;
(
    input wire logic       clk,           // System clock
    input wire logic       resetn,        // Async reset, active low
    input wire logic       sda_oe_n,      // Data pin pull enable
    input wire logic       adc_start,     // Conversion request
    input wire logic [1:0] adc_chan,      // Channel to convert
    input wire logic [1:0] sense_current, // Diode current select
    input wire logic       adc_done       // Conversion finished
);
    // ==========================================
    // Conversion sequencing
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_start_reset:
        assert property ($rose(resetn) |-> ##[0:2] adc_start)
        else $error("no start after reset");
    a_start_pulse:
        assert property (adc_start |=> !adc_start)
        else $error("start too long");
    a_start_after_done:
        assert property (adc_done |-> ##2 adc_start)
        else $error("no start after done");
    a_chan_hold:
        assert property (!adc_start |-> $stable(adc_chan))
        else $error("channel moved");
    a_chan_order:
        assert property (adc_start && $changed(adc_chan) |-> adc_chan ==
            (($past(adc_chan) == CHAN_LOCAL) ? CHAN_INPUT_ONE
            : $past(adc_chan) + 2'h1))
        else $error("channel order broken");
    a_chan_legal:
        assert property (adc_chan != 2'h3)
        else $error("bad channel");
    a_first_mult_base:
        assert property (adc_start && sense_current == CUR_FIRST_MULT
            |-> $past(sense_current, 2) == CUR_BASE)
        else $error("N1 not after base");
    a_second_mult_base:
        assert property (adc_start && sense_current == CUR_SECOND_MULT
            |-> $past(sense_current, 2) == CUR_BASE)
        else $error("N2 not after base");
    a_mult_chan:
        assert property (adc_start && sense_current != CUR_BASE
            |-> adc_chan == CHAN_INPUT_ONE)
        else $error("multiple off diode input");

    // Scenarios
    c_second_mult: cover property (adc_start && sense_current == 2'h2);
    c_local: cover property (adc_start && adc_chan == CHAN_LOCAL);
    c_ack: cover property ($fell(sda_oe_n));
endmodule

bind dimc_top dimc_properties dimc_properties_inst (.clk, .resetn,
    .sda_oe_n, .adc_start, .adc_chan, .sense_current, .adc_done);

// ### bench/dimc_sense_model.sv
`timescale 1ns/1ps
module dimc_sense_model
    import dimc_pkg::*;
(
    input  wire logic       clk,           // System clock
    input  wire logic       resetn,        // Reset, active low
    input  wire logic       adc_start,     // Conversion request
    input  wire logic [1:0] adc_chan,      // Channel asked for
    input  wire logic [1:0] sense_current, // Diode current
    input  wire logic [7:0] code_one,      // Level on input one
    input  wire logic [7:0] code_two,      // Level elsewhere
    input  wire logic [7:0] code_diode,    // Step per multiple
    input  wire logic [3:0] lat,           // Extra cycles
    output logic            adc_done,      // Result ready
    output logic [9:0]      adc_result     // Raw result
);
    // ==========================================
    // Converter
    logic       busy;
    logic [3:0] cnt;
    logic [7:0] code;

    // A multiple adds one diode step over the base level
    assign code = (adc_chan != CHAN_INPUT_ONE) ? code_two
                : (sense_current == CUR_BASE) ? code_one
                : code_one + code_diode;

    // Result toggles outside done so a stale value never passes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy       <= 1'b0;
            cnt        <= 4'h0;
            adc_done   <= 1'b0;
            adc_result <= 10'h2aa;
        end else begin
            adc_done   <= 1'b0;
            adc_result <= ~adc_result;
            if (adc_start) begin
                busy <= 1'b1;
                cnt  <= lat;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy       <= 1'b0;
                adc_done   <= 1'b1;
                adc_result <= {code, 2'b11}; // Low bits dropped
            end
        end
    end
endmodule

// ### bench/dimc_top_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end

module dimc_top_test
    import dimc_pkg::*;
;
    logic       clk, resetn, scl_in, sda_m, sda_in, adc_start, adc_done;
    logic       nc_diode_one, nc_diode_two, nc_therm_one, nc_therm_two;
    logic       sda_oe_n, sda_out;
    logic [1:0] adc_chan, sense_current;
    logic [9:0] adc_result;
    logic [7:0] code_one, code_two, code_diode, junk;
    logic [3:0] lat;
    int         error_cnt, n_tests;

    assign sda_in = sda_m & (sda_oe_n | sda_out); // Pull-up

    dimc_top dimc_top_inst (.clk, .resetn, .scl_in, .sda_in, .sda_out,
        .sda_oe_n, .adc_start, .adc_chan, .sense_current, .adc_done,
        .adc_result, .nc_diode_one, .nc_diode_two, .nc_therm_one,
        .nc_therm_two);
    dimc_sense_model dimc_sense_model_inst (.clk, .resetn, .adc_start,
        .adc_chan, .sense_current, .code_one, .code_two, .code_diode,
        .lat, .adc_done, .adc_result);

    // ==========================================
    // Bus master
    task automatic step(input logic c, input logic d);
        scl_in = c;
        repeat (3) @(negedge clk);
        sda_m = d;
        repeat (3) @(negedge clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, b);
        step(1'b1, b);
        r = sda_in;
    endtask
    task automatic send(input logic [7:0] b, input logic e);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        `CHK(r, e)
    endtask
    task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
        logic r;
        step(1'b0, 1'b1);
        step(1'b1, 1'b0);
        send({SMBUS_ADDRESS, 1'b0}, 1'b0);
        send(ofs, 1'b0);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        send({SMBUS_ADDRESS, 1'b1}, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(1'b1, r); // Master declines more data
        step(1'b0, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        step(1'b0, 1'b1);
        step(1'b1, 1'b0);
        send({SMBUS_ADDRESS, 1'b0}, 1'b0);
        send(ofs, 1'b0);
        send(d, 1'b0);
        step(1'b0, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic chk_rd(input logic [7:0] ofs, input logic [7:0] e);
        logic [7:0] d;
        rd(ofs, d);
        `CHK(d, e)
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset_regs;
        logic [7:0] ofs [12] = '{8'h01, 8'h02, 8'h05, 8'h10, 8'h11, 8'h12,
            8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h30};
        logic [7:0] ex [12] = '{8'h00, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
        wr(8'h10, 8'hff);
        wr(8'h30, 8'h5a);
        step(1'b1, 1'b0);
        send({~SMBUS_ADDRESS, 1'b0}, 1'b1);
        for (int i = 0; i < 12; i++) begin
            chk_rd(ofs[i], ex[i]);
        end
    endtask
    task automatic t_therm_nc;
        lat = 4'h9;
        {nc_therm_one, nc_therm_two, nc_diode_two} = 3'h7;
        wr(8'h13, 8'h0c);
        chk_rd(8'h13, 8'h0c);
        chk_rd(8'h11, 8'h30);
        {nc_therm_one, nc_therm_two, nc_diode_two} = 3'h0;
        rd(8'h11, junk);
        chk_rd(8'h11, 8'h00);
    endtask
    task automatic t_voltage;
        {lat, code_one, code_two} = {4'h0, 8'h20, 8'hff};
        wr(8'h05, 8'h00);
        wr(8'h02, 8'h00);
        wr(8'h14, 8'h30);
        wr(8'h17, 8'h80);
        nc_therm_one = 1'b1;
        repeat (100) @(posedge adc_done);
        @(negedge clk);
        chk_rd(8'h0a, 8'h20);
        chk_rd(8'h0b, 8'hff);
        chk_rd(8'h10, 8'h60);
        chk_rd(8'h11, 8'h00);
        wr(8'h14, 8'h00);
        wr(8'h17, 8'hff);
        rd(8'h10, junk);
        chk_rd(8'h10, 8'h00);
        nc_therm_two = 1'b1;
        for (int i = 0; i < 2; i++) begin
            wr(8'h02, 8'h40 << i);
            rd(8'h11, junk);
            chk_rd(8'h11, 8'h20 >> i);
        end
    endtask
    task automatic t_diode;
        {lat, code_diode} = {4'h5, 8'h40};
        {nc_diode_one, nc_diode_two} = 2'h3;
        wr(8'h01, 8'h80);
        wr(8'h13, 8'h30);
        wr(8'h12, 8'h20);
        chk_rd(8'h12, 8'h20);
        wr(8'h15, 8'h30);
        wr(8'h17, 8'h80);
        repeat (200) @(posedge adc_done);
        @(negedge clk);
        chk_rd(8'h0a, 8'h40);
        rd(8'h10, junk);
        chk_rd(8'h10, 8'h40);
        rd(8'h11, junk);
        chk_rd(8'h11, 8'h0c);
    endtask

    task automatic stop_test;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Main sequence
    initial begin
        resetn = 1'b0;
        {nc_diode_one, nc_diode_two, nc_therm_one, nc_therm_two} = 4'h0;
        {scl_in, sda_m, lat} = 6'h30;
        {code_one, code_two, code_diode} = 24'h0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        t_reset_regs;
        t_therm_nc;
        t_voltage;
        t_diode;
        stop_test;
    end

    // Watchdog
    initial begin
        #600000;
        error_cnt++;
        stop_test;
    end
endmodule

// ### common/dimc_pkg.sv
package dimc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_SECOND_CONFIG     = 8'h01;
    localparam logic [7:0] OFS_THIRD_CONFIG      = 8'h02;
    localparam logic [7:0] OFS_FAN_AUTO_CONFIG   = 8'h05;
    localparam logic [7:0] OFS_READING_ONE       = 8'h0a;
    localparam logic [7:0] OFS_READING_TWO       = 8'h0b;
    localparam logic [7:0] OFS_READING_LOCAL     = 8'h0e;
    localparam logic [7:0] OFS_EVENT_FLAGS_ONE   = 8'h10;
    localparam logic [7:0] OFS_EVENT_FLAGS_TWO   = 8'h11;
    localparam logic [7:0] OFS_EVENT_MASK_ONE    = 8'h12;
    localparam logic [7:0] OFS_EVENT_MASK_TWO    = 8'h13;
    localparam logic [7:0] OFS_IN_ONE_LOW_LIMIT  = 8'h14;
    localparam logic [7:0] OFS_IN_ONE_HIGH_LIMIT = 8'h15;
    localparam logic [7:0] OFS_IN_TWO_LOW_LIMIT  = 8'h16;
    localparam logic [7:0] OFS_IN_TWO_HIGH_LIMIT = 8'h17;

    // ==========================================================
    // Field positions
    localparam int BIT_DIODE_TWO_MODE   = 7;  // second_config
    localparam int BIT_AVERAGING_OFF    = 4;  // second_config
    localparam int BIT_THERMISTOR_ONE   = 7;  // third_config
    localparam int BIT_THERMISTOR_TWO   = 6;  // third_config
    localparam int BIT_OOL_INPUT_ONE    = 6;  // event_flags_one
    localparam int BIT_OOL_INPUT_TWO    = 5;  // event_flags_one
    localparam int BIT_NC_DIODE_ONE     = 2;  // event_flags_two
    localparam int BIT_NC_DIODE_TWO     = 3;  // event_flags_two
    localparam int BIT_NC_THERMISTOR_ONE = 4; // event_flags_two
    localparam int BIT_NC_THERMISTOR_TWO = 5; // event_flags_two

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_SECOND_CONFIG = 8'h00;
    localparam logic [7:0] RST_THIRD_CONFIG  = 8'hc0;
    localparam logic [7:0] RST_FAN_AUTO      = 8'h00;
    localparam logic [7:0] RST_MASK          = 8'h00;
    localparam logic [7:0] RST_LOW_LIMIT     = 8'h00;
    localparam logic [7:0] RST_HIGH_LIMIT    = 8'hff;
    localparam logic [7:0] RST_READING       = 8'h00;

    // ==========================================================
    // Measurement counts and encodings
    localparam logic [3:0] AVG_LAST_SAMPLE = 4'hf; // 16 samples averaged
    localparam logic [1:0] CHAN_INPUT_ONE  = 2'h0;
    localparam logic [1:0] CHAN_INPUT_TWO  = 2'h1;
    localparam logic [1:0] CHAN_LOCAL      = 2'h2;
    localparam logic [1:0] CUR_BASE        = 2'h0;
    localparam logic [1:0] CUR_FIRST_MULT  = 2'h1;
    localparam logic [1:0] CUR_SECOND_MULT = 2'h2;

    // Bus address; value is arbitrary
    localparam logic [6:0] SMBUS_ADDRESS   = 7'h2a;

endpackage

// ### design/dimc_smbus_slave.sv
`timescale 1ns/1ps
module dimc_smbus_slave
    import dimc_pkg::*;
(
    input  wire logic       clk,       // System clock
    input  wire logic       resetn,    // Async reset, active low
    input  wire logic       scl_in,    // Bus clock pin level
    input  wire logic       sda_in,    // Bus data pin level
    output logic            sda_oe_n,  // Low while pulling data low
    output logic [7:0]      reg_ptr,   // Current register pointer
    output logic            wr_pulse,  // One-cycle register write
    output logic [7:0]      wr_data,   // Data of the write
    output logic            rd_pulse,  // One-cycle read of reg_ptr
    input  wire logic [7:0] rd_data    // Data at reg_ptr
);
    typedef enum {
        SB_IDLE, SB_ADDR, SB_ACK_ADDR, SB_CMD, SB_ACK_CMD,
        SB_DATA, SB_ACK_DATA, SB_READ, SB_RACK
    } dimc_sb_state_t;

    dimc_sb_state_t state;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [3:0] cnt;
    logic       is_read;

    // ==========================================================
    // Pin synchronisers; bit 0 feeds bit 1 only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
        end
    end

    wire scl_rise = scl_s[1] & ~scl_s[2];
    wire scl_fall = ~scl_s[1] & scl_s[2];
    wire start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
    wire stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
    wire rx_state = (state == SB_ADDR) || (state == SB_CMD) ||
                    (state == SB_DATA);

    // ==========================================================
    // Byte protocol
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state    <= SB_IDLE;
            shreg    <= 8'h00;
            tx       <= 8'h00;
            cnt      <= 4'h0;
            is_read  <= 1'b0;
            sda_oe_n <= 1'b1;
            reg_ptr  <= 8'h00;
            wr_pulse <= 1'b0;
            wr_data  <= 8'h00;
            rd_pulse <= 1'b0;
        end else begin
            wr_pulse <= 1'b0;
            rd_pulse <= 1'b0;
            if (start_c) begin
                state    <= SB_ADDR;    // Repeated start too
                cnt      <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (stop_c) begin
                state    <= SB_IDLE;
                sda_oe_n <= 1'b1;
            end else if (scl_rise) begin
                if (rx_state || state == SB_READ) begin
                    shreg <= {shreg[6:0], sda_s[1]};
                    cnt   <= cnt + 4'h1;
                end else if (state == SB_RACK && sda_s[1]) begin
                    state <= SB_IDLE;   // Master said no more
                end
            end else if (scl_fall) begin
                case (state)
                    SB_ADDR: if (cnt == 4'h8) begin
                        if (shreg[7:1] == SMBUS_ADDRESS) begin
                            is_read  <= shreg[0];
                            sda_oe_n <= 1'b0;
                            state    <= SB_ACK_ADDR;
                        end else begin
                            state <= SB_IDLE; // Not for us
                        end
                    end
                    SB_CMD: if (cnt == 4'h8) begin
                        reg_ptr  <= shreg;
                        sda_oe_n <= 1'b0;
                        state    <= SB_ACK_CMD;
                    end
                    SB_DATA: if (cnt == 4'h8) begin
                        wr_data  <= shreg;
                        wr_pulse <= 1'b1;
                        sda_oe_n <= 1'b0;
                        state    <= SB_ACK_DATA;
                    end
                    SB_ACK_ADDR, SB_RACK: begin
                        cnt <= 4'h0;
                        if (is_read) begin
                            sda_oe_n <= rd_data[7];
                            tx       <= {rd_data[6:0], 1'b0};
                            rd_pulse <= 1'b1;
                            state    <= SB_READ;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state    <= SB_CMD;
                        end
                    end
                    SB_ACK_CMD, SB_ACK_DATA: begin
                        cnt      <= 4'h0;
                        sda_oe_n <= 1'b1;
                        state    <= SB_DATA;
                    end
                    SB_READ: begin
                        if (cnt == 4'h8) begin
                            sda_oe_n <= 1'b1;  // Free line for ack
                            state    <= SB_RACK;
                        end else begin
                            sda_oe_n <= tx[7];
                            tx       <= {tx[6:0], 1'b0};
                        end
                    end
                    default: state <= state;
                endcase
            end
        end
    end
endmodule

// ### design/dimc_top.sv
`timescale 1ns/1ps
// Overview of operation
// R1: Both shared inputs start as thermistors
// R2: Third config bits 7/6 pick thermistor
// R3: Second config bit 7 selects diode pair
// R4: Flags bits 2/3 report diode no-connection
// R5: Flags bits 4/5 report thermistor no-connection
// R6: Software masks unused no-connection alerts
// R7: Input one checked against 0x14/0x15 limits
// R8: Input two checked unless diode mode
// R9: Software disables fan control before voltage mode
// R10: Software masks input two in diode mode
// R11: Eight-bit code, saturating at 255
// R12: Average sixteen cycles before storing result
// R13: Diode current base/N1 then base/N2, combined
// R14: Limit violation sets its status bit
// R15: Only active-mode flags and readings evaluated (the diode one no-connection flag is set in every mode)
module dimc_top
    import dimc_pkg::*;
(
    input  wire logic       clk,           // 100 MHz system clock
    input  wire logic       resetn,        // Async reset, active low
    input  wire logic       scl_in,        // Bus clock pin
    input  wire logic       sda_in,        // Bus data pin level
    output logic            sda_out,       // Bus data drive level
    output logic            sda_oe_n,      // Low while driving data
    output logic            adc_start,     // Start one conversion
    output logic [1:0]      adc_chan,      // Channel to convert
    output logic [1:0]      sense_current, // Diode current select
    input  wire logic       adc_done,      // Conversion finished
    input  wire logic [9:0] adc_result,    // Raw 10-bit result
    input  wire logic       nc_diode_one,  // Diode one open/short
    input  wire logic       nc_diode_two,  // Diode two open/short
    input  wire logic       nc_therm_one,  // Thermistor one open/short
    input  wire logic       nc_therm_two   // Thermistor two open/short
);
    typedef enum { SQ_ISSUE, SQ_WAIT } dimc_seq_state_t;

    logic [7:0] second_config;
    logic [7:0] third_config;
    logic [7:0] fan_auto_config_one;
    logic [7:0] event_flags_one;
    logic [7:0] event_flags_two;
    logic [7:0] event_mask_one;
    logic [7:0] event_mask_two;
    logic [7:0] input_one_low_limit;
    logic [7:0] input_one_high_limit;
    logic [7:0] input_two_low_limit;
    logic [7:0] input_two_high_limit;
    logic [7:0] reading [3];

    logic [7:0] reg_ptr;
    logic       wr_pulse;
    logic [7:0] wr_data;
    logic       rd_pulse;
    logic [7:0] rd_data;

    assign sda_out = 1'b0;   // Open drain: only ever pulls low

    // ==========================================================
    // Serial management bus slave
    dimc_smbus_slave u_bus (
        .clk      (clk),
        .resetn   (resetn),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_oe_n (sda_oe_n),
        .reg_ptr  (reg_ptr),
        .wr_pulse (wr_pulse),
        .wr_data  (wr_data),
        .rd_pulse (rd_pulse),
        .rd_data  (rd_data)
    );

    // ==========================================================
    // Configuration, mask and limit registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            second_config        <= RST_SECOND_CONFIG;
            third_config         <= RST_THIRD_CONFIG;  // [R1]
            fan_auto_config_one  <= RST_FAN_AUTO;
            event_mask_one       <= RST_MASK;
            event_mask_two       <= RST_MASK;
            input_one_low_limit  <= RST_LOW_LIMIT;
            input_one_high_limit <= RST_HIGH_LIMIT;
            input_two_low_limit  <= RST_LOW_LIMIT;
            input_two_high_limit <= RST_HIGH_LIMIT;
        end else if (wr_pulse) begin
            case (reg_ptr)
                OFS_SECOND_CONFIG:     second_config        <= wr_data;
                OFS_THIRD_CONFIG:      third_config         <= wr_data;
                OFS_FAN_AUTO_CONFIG:   fan_auto_config_one  <= wr_data;
                OFS_EVENT_MASK_ONE:    event_mask_one       <= wr_data;
                OFS_EVENT_MASK_TWO:    event_mask_two       <= wr_data;
                OFS_IN_ONE_LOW_LIMIT:  input_one_low_limit  <= wr_data;
                OFS_IN_ONE_HIGH_LIMIT: input_one_high_limit <= wr_data;
                OFS_IN_TWO_LOW_LIMIT:  input_two_low_limit  <= wr_data;
                OFS_IN_TWO_HIGH_LIMIT: input_two_high_limit <= wr_data;
                default: ;            // Ignored
            endcase
        end
    end

    // Mode decode
    wire diode_mode = second_config[BIT_DIODE_TWO_MODE];          // [R3]
    wire therm_one  = third_config[BIT_THERMISTOR_ONE];           // [R2]
    wire therm_two  = third_config[BIT_THERMISTOR_TWO];           // [R2]
    wire avg_on     = ~second_config[BIT_AVERAGING_OFF];

    // ==========================================================
    // Measurement sequencer
    dimc_seq_state_t seq;
    logic [1:0] chan;
    logic [1:0] phase;
    logic [3:0] nsamp;
    logic [11:0] acc;
    logic [7:0] base_code;
    logic [7:0] delta_one;

    // Top 8 of 10 bits: one step per 8.8 mV, full scale is 255
    wire [7:0] code8      = adc_result[9:2];                      // [R11]
    wire       diode_chan = diode_mode && (chan == CHAN_INPUT_ONE);
    wire [8:0] delta_sum  = {1'b0, delta_one} +
                            {1'b0, code8 - base_code};
    wire [7:0] sample     = diode_chan ? delta_sum[8:1] : code8;  // [R13]
    wire [11:0] acc_sum   = acc + {4'h0, sample};
    wire       last_phase = !diode_chan || (phase == 2'h3);
    wire       store      = !avg_on || (nsamp == AVG_LAST_SAMPLE);

    // Current step for each diode phase: base, N1, base, N2
    always_comb begin
        case (phase)
            2'h1:    sense_current = CUR_FIRST_MULT;               // [R13]
            2'h3:    sense_current = CUR_SECOND_MULT;              // [R13]
            default: sense_current = CUR_BASE;
        endcase
        if (!diode_chan)
            sense_current = CUR_BASE;
    end

    // Conversion sequencing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seq       <= SQ_ISSUE;
            adc_start <= 1'b0;
            adc_chan  <= CHAN_INPUT_ONE;
            chan      <= CHAN_INPUT_ONE;
            phase     <= 2'h0;
            nsamp     <= 4'h0;
            acc       <= 12'h000;
            base_code <= 8'h00;
            delta_one <= 8'h00;
        end else begin
            adc_start <= 1'b0;
            case (seq)
                SQ_ISSUE: begin
                    adc_start <= 1'b1;
                    adc_chan  <= chan;
                    seq       <= SQ_WAIT;
                end
                SQ_WAIT: if (adc_done) begin
                    seq <= SQ_ISSUE;
                    if (diode_chan && phase[0] == 1'b0)
                        base_code <= code8;
                    if (diode_chan && phase == 2'h1)
                        delta_one <= code8 - base_code;            // [R13]
                    phase <= last_phase ? 2'h0 : phase + 2'h1;
                    if (last_phase) begin
                        if (store) begin
                            acc   <= 12'h000;
                            nsamp <= 4'h0;
                            chan  <= (chan == CHAN_LOCAL) ?
                                     CHAN_INPUT_ONE : chan + 2'h1;
                        end else begin
                            acc   <= acc_sum;                      // [R12]
                            nsamp <= nsamp + 4'h1;
                        end
                    end
                end
                default: seq <= SQ_ISSUE;
            endcase
        end
    end

    // Result store
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reading[0] <= RST_READING;
            reading[1] <= RST_READING;
            reading[2] <= RST_READING;
        end else if (seq == SQ_WAIT && adc_done && last_phase && store) begin
            reading[chan] <= avg_on ? acc_sum[11:4] : sample;      // [R12]
        end
    end

    // ==========================================================
    // Limit checks and no-connection flags
    // Reading at index 0 is the diode result in diode mode, so the
    // same limits serve whichever source is active.
    wire ool_one = (reading[0] < input_one_low_limit) ||
                   (reading[0] > input_one_high_limit);            // [R7]
    wire ool_two = !diode_mode &&
                   ((reading[1] < input_two_low_limit) ||
                    (reading[1] > input_two_high_limit));          // [R8]

    logic [7:0] set_one;
    logic [7:0] set_two;
    always_comb begin
        set_one = 8'h00;
        set_two = 8'h00;
        set_one[BIT_OOL_INPUT_ONE] = ool_one;                      // [R14]
        set_one[BIT_OOL_INPUT_TWO] = ool_two;                      // [R14]
        set_two[BIT_NC_DIODE_ONE]  = nc_diode_one;                 // [R4]
        set_two[BIT_NC_DIODE_TWO]  = diode_mode & nc_diode_two;    // [R15]
        set_two[BIT_NC_THERMISTOR_ONE] =
            !diode_mode & therm_one & nc_therm_one;                // [R5]
        set_two[BIT_NC_THERMISTOR_TWO] =
            !diode_mode & therm_two & nc_therm_two;                // [R5]
    end

    // Sticky flags cleared by a read; a live condition re-sets at once
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            event_flags_one <= 8'h00;
            event_flags_two <= 8'h00;
        end else begin
            event_flags_one <= ((rd_pulse &&
                                 reg_ptr == OFS_EVENT_FLAGS_ONE) ?
                                8'h00 : event_flags_one) | set_one;
            event_flags_two <= ((rd_pulse &&
                                 reg_ptr == OFS_EVENT_FLAGS_TWO) ?
                                8'h00 : event_flags_two) | set_two;
        end
    end

    // ==========================================================
    // Read mux; unmapped addresses read as zero
    always_comb begin
        case (reg_ptr)
            OFS_SECOND_CONFIG:     rd_data = second_config;
            OFS_THIRD_CONFIG:      rd_data = third_config;
            OFS_FAN_AUTO_CONFIG:   rd_data = fan_auto_config_one;
            OFS_READING_ONE:       rd_data = reading[0];
            OFS_READING_TWO:       rd_data = reading[1];
            OFS_READING_LOCAL:     rd_data = reading[2];
            OFS_EVENT_FLAGS_ONE:   rd_data = event_flags_one;
            OFS_EVENT_FLAGS_TWO:   rd_data = event_flags_two;
            OFS_EVENT_MASK_ONE:    rd_data = event_mask_one;
            OFS_EVENT_MASK_TWO:    rd_data = event_mask_two;
            OFS_IN_ONE_LOW_LIMIT:  rd_data = input_one_low_limit;
            OFS_IN_ONE_HIGH_LIMIT: rd_data = input_one_high_limit;
            OFS_IN_TWO_LOW_LIMIT:  rd_data = input_two_low_limit;
            OFS_IN_TWO_HIGH_LIMIT: rd_data = input_two_high_limit;
            default:               rd_data = 8'h00;
        endcase
    end
endmodule
